// [verilog/nvps_pkg.sv]
// Constants for the non-volatile parameter store.
// Assumes one 100 MHz clock and a parsed command stream from the host side.
//
// Contract
// - One retained user byte; save writes it, read returns it.
// - Parameter values and enable flags are retained across power loss.
// - Every reset loads enabled parameters over the built-in defaults.
// - Set-value stores a byte unenabled; a separate enable command activates it.
// - Enabling a defaults-type parameter leaves the active setting unchanged.
// - Summary lists every parameter 00..2F with value and N/F flag.
// - Parameter 26 is the CAN filler byte; 00 when not enabled.
// - All-off command at number FF disables every parameter at once.
// - Only the configured line-end character terminates a command.
// - Power-up with activity output grounded disables all parameters.
// - After a forced clear the receive indicator flashes rapidly.
// - Parameter 01 gives the header-display default; 00 shows headers.
// - Each parameter has an effect class: immediate, defaults, reset, power.
// - Header parameter: 00 on, FF off, factory default FF.
`default_nettype none
package nvps_pkg;
    localparam int NVPS_NUM = 48;
    localparam logic [7:0] NVPS_LAST = 8'h2F;
    localparam logic [7:0] NVPS_ALL = 8'hFF;
    localparam logic [7:0] OFS_HEADER_DISPLAY_DEFAULT = 8'h01;
    localparam logic [7:0] OFS_LINE_END_CHARACTER = 8'h0D;
    localparam logic [7:0] OFS_CAN_FILLER_BYTE = 8'h26;
    localparam logic [7:0] HDR_ON = 8'h00;
    localparam logic [7:0] HDR_OFF = 8'hFF;
    localparam logic [7:0] RST_HEADER = 8'hFF;
    localparam logic [7:0] RST_LINE_END = 8'h0D;
    localparam logic [7:0] RST_FILLER = 8'h00;
    localparam logic [7:0] RST_ERASED = 8'hFF;
    localparam logic [7:0] RST_USER = 8'hFF;
    localparam logic [7:0] CHR_ON = 8'h4E;
    localparam logic [7:0] CHR_OFF = 8'h46;
    localparam int FLASH_HALF_NS = 100_000_000;
    localparam int CLK_NS = 10;
    localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_NS;
    localparam logic [4:0] FLASH_TOGGLES = 5'h14;
    localparam logic [1:0] CLS_IMMEDIATE = 2'h0;
    localparam logic [1:0] CLS_DEFAULTS = 2'h1;
    localparam logic [1:0] CLS_RESET = 2'h2;
    localparam logic [1:0] CLS_POWER = 2'h3;
    typedef enum logic [2:0] {
        NVPS_IDLE = 3'h0,
        NVPS_LOAD = 3'h1,
        NVPS_LIST = 3'h2,
        NVPS_CLEAR = 3'h3
    } nvps_state_t;
endpackage
`default_nettype wire

// [verilog/nvps_store.sv]
// Non-volatile parameter store with user byte, summary and forced clear.
// Assumes commands arrive parsed, one cycle pulses, synchronous to i_clk_sys;
// the retained arrays model storage that keeps contents across i_rst.
`default_nettype none
module nvps_store #(
    parameter int FLASH_CYC = nvps_pkg::FLASH_HALF_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_power_up,
    input wire logic i_tx_led_in,
    input wire logic i_restore_defaults_command,
    input wire logic i_set_value_subcommand,
    input wire logic i_enable_command,
    input wire logic i_disable_command,
    input wire logic [7:0] i_param_num,
    input wire logic [7:0] i_param_value,
    input wire logic i_save_user,
    input wire logic i_read_user,
    input wire logic [7:0] i_user_data,
    input wire logic i_parameter_summary_command,
    input wire logic i_rx_char_valid,
    input wire logic [7:0] i_rx_char,
    output logic o_user_valid,
    output logic [7:0] o_user_data,
    output logic o_sum_valid,
    output logic [7:0] o_sum_num,
    output logic [7:0] o_sum_value,
    output logic [7:0] o_sum_flag,
    output logic o_sum_done,
    output logic o_cmd_end,
    output logic o_busy,
    output logic [7:0] o_header_display_default,
    output logic [7:0] o_line_end_character,
    output logic [7:0] o_can_filler_byte,
    output logic o_clear_done,
    output logic o_rx_led
);
    import nvps_pkg::*;

    // Effect class of a parameter
    function automatic logic [1:0] param_class(input logic [7:0] n);
        case (n)
            OFS_HEADER_DISPLAY_DEFAULT: param_class = CLS_DEFAULTS;
            OFS_CAN_FILLER_BYTE: param_class = CLS_DEFAULTS;
            OFS_LINE_END_CHARACTER: param_class = CLS_RESET;
            default: param_class = CLS_IMMEDIATE;
        endcase
    endfunction

    // Value used when a parameter is not enabled
    function automatic logic [7:0] param_default(input logic [7:0] n);
        case (n)
            OFS_HEADER_DISPLAY_DEFAULT: param_default = RST_HEADER;
            OFS_LINE_END_CHARACTER: param_default = RST_LINE_END;
            OFS_CAN_FILLER_BYTE: param_default = RST_FILLER;
            default: param_default = RST_ERASED;
        endcase
    endfunction

    // Retained storage: no reset term, so contents persist across i_rst
    logic [7:0] val_mem [NVPS_NUM];
    logic en_mem [NVPS_NUM];
    logic [7:0] user_mem;

    nvps_state_t state_q, state_d;
    logic [7:0] idx_q, idx_d;
    logic [7:0] hdr_q, hdr_d, eol_q, eol_d, fill_q, fill_d;
    logic power_q, power_d;
    logic user_valid_q, user_valid_d;
    logic [7:0] user_out_q, user_out_d;
    logic sum_valid_q, sum_valid_d, sum_done_q, sum_done_d;
    logic [7:0] sum_num_q, sum_num_d, sum_val_q, sum_val_d, sum_flag_q;
    logic [7:0] sum_flag_d;
    logic cmd_end_q, cmd_end_d;
    logic clear_done_q, clear_done_d;
    logic [4:0] flash_left_q, flash_left_d;
    logic [31:0] flash_cnt_q, flash_cnt_d;
    logic led_q, led_d;
    logic in_range;
    logic [5:0] idx6, num6;
    logic busy_q, busy_d;
    logic strap_q, strap_d;

    assign in_range = (i_param_num <= NVPS_LAST);
    assign idx6 = idx_q[5:0];
    assign num6 = i_param_num[5:0];

    always_comb
    begin
        state_d = state_q;
        idx_d = idx_q;
        hdr_d = hdr_q;
        eol_d = eol_q;
        fill_d = fill_q;
        power_d = power_q;
        user_valid_d = 1'b0;
        user_out_d = user_out_q;
        sum_valid_d = 1'b0;
        sum_done_d = 1'b0;
        sum_num_d = sum_num_q;
        sum_val_d = sum_val_q;
        sum_flag_d = sum_flag_q;
        cmd_end_d = i_rx_char_valid && (i_rx_char == eol_q);
        clear_done_d = 1'b0;
        flash_left_d = flash_left_q;
        flash_cnt_d = flash_cnt_q;
        led_d = led_q;
        case (state_q)
            NVPS_CLEAR:
            begin
                // Walk every entry; the enable goes only when strapped, value stays
                if (idx_q == NVPS_LAST)
                begin
                    state_d = NVPS_LOAD;
                    idx_d = 8'h00;
                    clear_done_d = 1'b1;
                    // Flash only when the strap really cleared the store
                    if (strap_q)
                        flash_left_d = FLASH_TOGGLES;
                end
                else
                begin
                    idx_d = idx_q + 8'h01;
                end
            end
            NVPS_LOAD:
            begin
                // Enabled entries replace defaults, else defaults apply
                case (idx_q)
                    OFS_HEADER_DISPLAY_DEFAULT: hdr_d = en_mem[idx6] ?
                        val_mem[idx6] : param_default(idx_q);
                    OFS_CAN_FILLER_BYTE: fill_d = en_mem[idx6] ?
                        val_mem[idx6] : param_default(idx_q);
                    // Reset-class entry waits for the walk after reset
                    OFS_LINE_END_CHARACTER:
                        if (param_class(idx_q) == CLS_DEFAULTS || power_q)
                            eol_d = en_mem[idx6] ?
                                val_mem[idx6] : param_default(idx_q);
                    default: ;
                endcase
                if (idx_q == NVPS_LAST)
                begin
                    state_d = NVPS_IDLE;
                    power_d = 1'b0;
                end
                else
                begin
                    idx_d = idx_q + 8'h01;
                end
            end
            NVPS_LIST:
            begin
                sum_valid_d = 1'b1;
                sum_num_d = idx_q;
                sum_val_d = val_mem[idx6];
                sum_flag_d = en_mem[idx6] ? CHR_ON : CHR_OFF;
                if (idx_q == NVPS_LAST)
                begin
                    state_d = NVPS_IDLE;
                    sum_done_d = 1'b1;
                end
                else
                begin
                    idx_d = idx_q + 8'h01;
                end
            end
            default:
            begin
                if (i_restore_defaults_command)
                begin
                    // Defaults-class entries only; reset class waits
                    state_d = NVPS_LOAD;
                    idx_d = 8'h00;
                end
                else if (i_parameter_summary_command)
                begin
                    state_d = NVPS_LIST;
                    idx_d = 8'h00;
                end
                if (i_read_user)
                begin
                    user_valid_d = 1'b1;
                    user_out_d = user_mem;
                end
            end
        endcase
        if (flash_left_q != 5'h00)
        begin
            if (flash_cnt_q >= 32'(FLASH_CYC - 1))
            begin
                flash_cnt_d = 32'h0;
                led_d = ~led_q;
                flash_left_d = flash_left_q - 5'h01;
            end
            else
            begin
                flash_cnt_d = flash_cnt_q + 32'h1;
            end
        end
        else
        begin
            led_d = 1'b0;
        end
        busy_d = (state_d != NVPS_IDLE);
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= NVPS_CLEAR;
            idx_q <= 8'h00;
            busy_q <= 1'b1;
            hdr_q <= RST_HEADER;
            eol_q <= RST_LINE_END;
            fill_q <= RST_FILLER;
            power_q <= 1'b1;
            user_valid_q <= 1'b0;
            user_out_q <= 8'h00;
            sum_valid_q <= 1'b0;
            sum_done_q <= 1'b0;
            sum_num_q <= 8'h00;
            sum_val_q <= 8'h00;
            sum_flag_q <= 8'h00;
            cmd_end_q <= 1'b0;
            clear_done_q <= 1'b0;
            flash_left_q <= 5'h00;
            flash_cnt_q <= 32'h0;
            led_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            busy_q <= busy_d;
            idx_q <= idx_d;
            hdr_q <= hdr_d;
            eol_q <= eol_d;
            fill_q <= fill_d;
            power_q <= power_d;
            user_valid_q <= user_valid_d;
            user_out_q <= user_out_d;
            sum_valid_q <= sum_valid_d;
            sum_done_q <= sum_done_d;
            sum_num_q <= sum_num_d;
            sum_val_q <= sum_val_d;
            sum_flag_q <= sum_flag_d;
            cmd_end_q <= cmd_end_d;
            clear_done_q <= clear_done_d;
            flash_left_q <= flash_left_d;
            flash_cnt_q <= flash_cnt_d;
            led_q <= led_d;
        end
    end

    // Strap decision at the first entry of the clear walk, then held
    always_comb
    begin
        strap_d = strap_q;
        if (state_q == NVPS_CLEAR && idx_q == 8'h00)
            strap_d = power_q && i_power_up && !i_tx_led_in;
    end
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            strap_q <= 1'b0;
        else
            strap_q <= strap_d;
    end

    // Retained storage writes; ignored while a walk is running
    always_ff @(posedge i_clk_sys)
    begin
        if (state_q == NVPS_CLEAR)
        begin
            if (strap_d || strap_q)
                en_mem[idx6] <= 1'b0;
        end
        else if (state_q == NVPS_IDLE)
        begin
            if (i_save_user)
                user_mem <= i_user_data;
            if (i_set_value_subcommand && in_range)
                val_mem[num6] <= i_param_value;
            if (i_enable_command && in_range)
                en_mem[num6] <= 1'b1;
            if (i_disable_command && in_range)
                en_mem[num6] <= 1'b0;
            if (i_disable_command && i_param_num == NVPS_ALL)
                for (int k = 0; k < NVPS_NUM; k++)
                    en_mem[k] <= 1'b0;
        end
    end

    assign o_user_valid = user_valid_q;
    assign o_user_data = user_out_q;
    assign o_sum_valid = sum_valid_q;
    assign o_sum_num = sum_num_q;
    assign o_sum_value = sum_val_q;
    assign o_sum_flag = sum_flag_q;
    assign o_sum_done = sum_done_q;
    assign o_cmd_end = cmd_end_q;
    assign o_busy = busy_q;
    assign o_header_display_default = hdr_q;
    assign o_line_end_character = eol_q;
    assign o_can_filler_byte = fill_q;
    assign o_clear_done = clear_done_q;
    assign o_rx_led = led_q;
endmodule // nvps_store
`default_nettype wire

// [tb/nvps_store_sva.sv]
// Port-level assertions for the parameter store.
// Assumes one clock domain and an asynchronous active-high reset.
`default_nettype none
module nvps_store_chk
    import nvps_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_read_user,
    input wire logic i_restore_defaults_command,
    input wire logic i_parameter_summary_command,
    input wire logic i_rx_char_valid,
    input wire logic [7:0] i_rx_char,
    input wire logic o_user_valid,
    input wire logic o_busy,
    input wire logic o_sum_valid,
    input wire logic [7:0] o_sum_num,
    input wire logic [7:0] o_sum_flag,
    input wire logic o_sum_done,
    input wire logic o_cmd_end,
    input wire logic [7:0] o_line_end_character,
    input wire logic [7:0] o_can_filler_byte
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence sum_req;
        i_parameter_summary_command && !o_busy && !i_restore_defaults_command;
    endsequence
    sequence first_entry;
        o_sum_valid && o_sum_num == 8'h00;
    endsequence
    chk_user_read: assert property (
        i_read_user && !o_busy |=> o_user_valid) else $error("no user read");
    chk_sum_start: assert property (
        sum_req |-> ##2 first_entry) else $error("summary start");
    chk_sum_walk: assert property (
        o_sum_valid && !o_sum_done |=> o_sum_valid &&
        o_sum_num == $past(o_sum_num) + 8'h01) else $error("summary step");
    chk_sum_end: assert property (
        o_sum_done |-> o_sum_valid && o_sum_num == NVPS_LAST)
        else $error("summary end");
    chk_sum_flag: assert property (
        o_sum_valid |-> o_sum_flag == CHR_ON || o_sum_flag == CHR_OFF)
        else $error("summary flag");
    chk_eol_hit: assert property (
        i_rx_char_valid && !o_busy && i_rx_char == o_line_end_character
        |=> o_cmd_end) else $error("line end missed");
    chk_eol_only: assert property (
        o_cmd_end |-> $past(i_rx_char_valid) &&
        $past(i_rx_char) == $past(o_line_end_character))
        else $error("false end");
    chk_fill_quiet: assert property (
        !o_busy && !$past(o_busy) |-> $stable(o_can_filler_byte))
        else $error("filler moved");
endmodule // nvps_store_chk
bind nvps_store nvps_store_chk chk_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_read_user(i_read_user), .o_user_valid(o_user_valid),
    .i_restore_defaults_command(i_restore_defaults_command),
    .i_parameter_summary_command(i_parameter_summary_command),
    .i_rx_char_valid(i_rx_char_valid), .i_rx_char(i_rx_char),
    .o_busy(o_busy), .o_sum_valid(o_sum_valid), .o_sum_num(o_sum_num),
    .o_sum_flag(o_sum_flag), .o_sum_done(o_sum_done), .o_cmd_end(o_cmd_end),
    .o_line_end_character(o_line_end_character),
    .o_can_filler_byte(o_can_filler_byte));
`default_nettype wire

// [tb/nvps_host.sv]
// Host model: issues one parsed command pulse per call.
// Bits: restore, set value, enable, disable, save, read, summary, rx char.
`default_nettype none
module nvps_host (
    input wire logic i_clk_sys,
    output logic [7:0] o_cmd,
    output logic [7:0] o_num,
    output logic [7:0] o_val
);
    initial
    begin
        o_cmd = 8'h00;
        o_num = 8'h00;
        o_val = 8'h00;
    end
    task automatic issue(input int idx, input logic [7:0] num,
                         input logic [7:0] val);
        @(posedge i_clk_sys);
        o_cmd <= 8'h01 << idx;
        o_num <= num;
        o_val <= val;
        @(posedge i_clk_sys);
        o_cmd <= 8'h00;
        o_num <= ~num;
        o_val <= ~val;
    endtask
endmodule // nvps_host
`default_nettype wire

// [tb/tb_nvps_store.sv]
// Self-checking bench for the parameter store.
// Assumes the host model drives all command pulses.
`default_nettype none
module tb_nvps_store import nvps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 1'b0, i_rst, i_power_up, i_tx_led_in;
    logic [7:0] cmd, num, val, o_user_data, o_sum_num, o_sum_value, o_sum_flag;
    logic [7:0] o_hdr, o_eol, o_fill;
    logic o_user_valid, o_sum_valid, o_sum_done, o_cmd_end, o_busy;
    logic o_clear_done, o_rx_led;
    int failures = 0, n_compared = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    nvps_host host_u (.i_clk_sys(i_clk_sys), .o_cmd(cmd), .o_num(num),
        .o_val(val));
    nvps_store #(.FLASH_CYC(4)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_power_up(i_power_up), .i_tx_led_in(i_tx_led_in),
        .i_restore_defaults_command(cmd[0]), .i_set_value_subcommand(cmd[1]),
        .i_enable_command(cmd[2]), .i_disable_command(cmd[3]),
        .i_save_user(cmd[4]), .i_read_user(cmd[5]),
        .i_parameter_summary_command(cmd[6]), .i_rx_char_valid(cmd[7]),
        .i_param_num(num), .i_param_value(val), .i_user_data(val),
        .i_rx_char(val),
        .o_user_valid(o_user_valid), .o_user_data(o_user_data),
        .o_sum_valid(o_sum_valid), .o_sum_num(o_sum_num),
        .o_sum_value(o_sum_value), .o_sum_flag(o_sum_flag),
        .o_sum_done(o_sum_done), .o_cmd_end(o_cmd_end), .o_busy(o_busy),
        .o_header_display_default(o_hdr), .o_line_end_character(o_eol),
        .o_can_filler_byte(o_fill), .o_clear_done(o_clear_done),
        .o_rx_led(o_rx_led));
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string msg);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 300; i++)
        begin
            @(posedge i_clk_sys);
            #1;
            if (o_busy === 1'b0) return;
        end
        chk(16'h0000, 16'h0001, "busy hang");
        report_and_stop();
    endtask
    task automatic do_reset(input logic pu, tx);
        int seen;
        seen = 0;
        @(posedge i_clk_sys);
        i_power_up <= pu;
        i_tx_led_in <= tx;
        i_rst <= 1'b1;
        repeat (19) @(posedge i_clk_sys);
        #1 chk({o_hdr, o_eol}, 16'hFF0D, "reset values");
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (100)
        begin
            @(posedge i_clk_sys);
            #1 if (o_clear_done === 1'b1) seen++;
        end
        chk(16'(seen), 16'h0001, "clear walk");
        wait_idle();
        @(posedge i_clk_sys);
        i_power_up <= 1'b0;
        i_tx_led_in <= 1'b1;
        #1;
    endtask
    task automatic rx_try(input logic [7:0] c, input logic e);
        host_u.issue(7, 8'h00, c);
        #1 chk(16'(o_cmd_end), 16'(e), "line end");
    endtask
    task automatic s_forced();
        int flips;
        logic prev;
        flips = 0;
        do_reset(1'b1, 1'b0);
        chk({o_hdr, o_fill}, 16'hFF00, "factory values");
        prev = o_rx_led;
        repeat (40)
        begin
            @(posedge i_clk_sys);
            #1 if (o_rx_led !== prev) flips++;
            prev = o_rx_led;
        end
        chk(16'(flips >= 4), 16'h0001, "no flash");
        rx_try(8'h0D, 1'b1);
        rx_try(8'h0A, 1'b0);
    endtask
    task automatic s_user();
        host_u.issue(4, 8'h00, 8'h7F);
        host_u.issue(5, 8'h00, 8'h00);
        #1 chk({7'h00, o_user_valid, o_user_data}, 16'h017F, "user");
    endtask
    task automatic s_two_step();
        host_u.issue(1, OFS_CAN_FILLER_BYTE, 8'hAA);
        host_u.issue(1, OFS_HEADER_DISPLAY_DEFAULT, 8'h00);
        host_u.issue(2, OFS_CAN_FILLER_BYTE, 8'h00);
        host_u.issue(2, OFS_HEADER_DISPLAY_DEFAULT, 8'h00);
        #1 chk({o_hdr, o_fill}, 16'hFF00, "enable applied early");
        host_u.issue(0, 8'h00, 8'h00);
        wait_idle();
        chk({o_hdr, o_fill}, 16'h00AA, "restore");
    endtask
    task automatic s_summary(input logic [7:0] f);
        host_u.issue(6, 8'h00, 8'h00);
        // First entry is registered one cycle after the walk starts
        @(posedge i_clk_sys);
        for (int i = 0; i < NVPS_NUM; i++)
        begin
            #1;
            chk({o_sum_num, 7'h00, o_sum_valid}, {i[7:0], 8'h01}, "num");
            chk(16'(o_sum_done), 16'(i == NVPS_NUM - 1), "done");
            if (i == int'(OFS_CAN_FILLER_BYTE))
                chk({o_sum_value, o_sum_flag}, {8'hAA, f}, "26");
            if (i == int'(OFS_HEADER_DISPLAY_DEFAULT))
                chk({o_sum_value, o_sum_flag}, {8'h00, f}, "01");
            @(posedge i_clk_sys);
        end
        wait_idle();
    endtask
    task automatic s_all_off();
        host_u.issue(3, NVPS_ALL, 8'h00);
        s_summary(CHR_OFF);
        host_u.issue(0, 8'h00, 8'h00);
        wait_idle();
        chk({o_hdr, o_fill}, 16'hFF00, "all off");
    endtask
    task automatic s_line_end();
        host_u.issue(1, OFS_LINE_END_CHARACTER, 8'h0A);
        host_u.issue(2, OFS_LINE_END_CHARACTER, 8'h00);
        host_u.issue(0, 8'h00, 8'h00);
        wait_idle();
        chk(16'(o_eol), 16'h000D, "line end on restore");
        do_reset(1'b0, 1'b1);
        chk(16'(o_eol), 16'h000A, "line end load");
        chk(16'(o_rx_led), 16'h0000, "led on plain reset");
        host_u.issue(5, 8'h00, 8'h00);
        #1 chk({7'h00, o_user_valid, o_user_data}, 16'h017F, "kept");
        rx_try(8'h0D, 1'b0);
        rx_try(8'h0A, 1'b1);
        s_user();
        do_reset(1'b1, 1'b0);
        chk(16'(o_eol), 16'h000D, "forced clear");
    endtask
    initial
    begin
        i_rst = 1'b1;
        i_power_up = 1'b1;
        i_tx_led_in = 1'b0;
        s_forced();
        s_user();
        s_two_step();
        s_summary(CHR_ON);
        s_all_off();
        s_line_end();
        report_and_stop();
    end
endmodule // tb_nvps_store
`default_nettype wire
